// >>> design/ier_defines.vh
// constants for the interrupt entry and return sequencer
`ifndef IER_DEFINES_VH
`define IER_DEFINES_VH

// register byte offsets
`define IER_OFS_ENABLE   12'h000
`define IER_OFS_LATCH    12'h004
`define IER_OFS_STATUS   12'h008
`define IER_OFS_SP       12'h00c

// field positions and widths
`define IER_IMF_BIT      0
`define IER_NMI_LO       2
`define IER_NMI_HI       3
`define IER_MASK_LO      4
`define IER_SRC_HI       15
`define IER_PSW_IMF_BIT  0

// reset values
`define IER_SP_RST       8'hff
`define IER_EN_RST       16'h0000
`define IER_LATCH_RST    16'h0000

// vectors and opcodes
`define IER_VEC_TOP      16'hfffe
`define IER_VEC_TRAP     16'hfffc
`define IER_TRAP_IDX     4'h1
`define IER_OPC_SWI      8'hff

// stack moves
`define IER_STACK_BYTES  8'h03
`define IER_ONE          8'h01
`define IER_TWO          8'h02

`endif

// >>> design/ier_stack_ram.v
// byte stack memory with registered read data
`timescale 1ns/10ps
module ier_stack_ram #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_ff
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ==========================================
    // write port
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // ==========================================
    // registered read port
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= {DW{1'b0}};
        end else begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule

// >>> design/ier_core_irq.v
// interrupt acceptance, stacking and return sequencer with apb registers
`timescale 1ns/10ps
`include "ier_defines.vh"
//
// Function
// (RL1) acceptance clears master enable
// (RL2) acceptance clears only accepted source latch
// (RL3) push status, pc high, pc low; sp minus three
// (RL4) load pc from source vector slot
// (RL5) accept within 38 tc of latch
// (RL6) master enable low blocks all maskable requests
// (RL7) software disables source before nesting enable
// (RL8) only pc and status saved
// (RL9) returns restore pc, status; sp plus three
// (RL10) pc low at sp+1, high sp+2
// (RL11) fetch trap routine rewrites stacked pc
// (RL12) requests sampled in last instruction cycle
// (RL13) software trap starts processing at once
// (RL14) missing memory fetch returns ff opcode
// (RL15) fetch from ram or sfr resets
// (RL16) undefined opcode raises illegal opcode interrupt
// (RL17) illegal opcode aborts any processing
// (RL18) illegal opcode jumps like software trap
// (RL19) traps share fffc, reset uses fffe
// (RL20) maskable needs latch, source enable, master
// (RL21) non-maskable ignores enable register
// (RL22) highest priority first, others stay latched
module ier_core_irq #(
    parameter SFR_TOP  = 16'h003f,
    parameter RAM_TOP  = 16'h00ff,
    parameter ROM_BASE = 16'hf000
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata_ff,
    output reg         pready_ff,
    output reg         pslverr_ff,
    input  wire [15:2] irq_src_req,
    input  wire        instr_last,
    input  wire        swi_exec,
    input  wire        undef_exec,
    input  wire        ret_exec,
    input  wire [15:0] core_pc,
    input  wire [7:0]  core_psw,
    input  wire [15:0] vec_data,
    input  wire        single_chip,
    input  wire        fetch_valid,
    input  wire [15:0] fetch_addr,
    input  wire [7:0]  fetch_rdata,
    output reg         core_hold_ff,
    output reg         pc_load_ff,
    output reg  [15:0] pc_value_ff,
    output reg         psw_load_ff,
    output reg  [7:0]  psw_value_ff,
    output reg  [15:0] vec_addr_ff,
    output reg         vec_rd_ff,
    output reg         master_irq_enable_ff,
    output reg  [7:0]  fetch_opcode_ff,
    output reg         addr_trap_rst_ff,
    output reg  [7:0]  sp_ff
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_PSH0 = 4'h1;
    localparam [3:0] ST_PSH1 = 4'h2;
    localparam [3:0] ST_PSH2 = 4'h3;
    localparam [3:0] ST_VEC  = 4'h4;
    localparam [3:0] ST_VECW = 4'h5;
    localparam [3:0] ST_POP0 = 4'h6;
    localparam [3:0] ST_POP1 = 4'h7;
    localparam [3:0] ST_POP2 = 4'h8;
    localparam [3:0] ST_POP3 = 4'h9;

    reg  [3:0]  state_ff;
    reg  [15:0] source_irq_enable_ff;
    reg  [15:0] irq_pending_latch_ff;
    reg  [3:0]  src_ff;
    reg  [15:0] pc_sav_ff;
    reg  [7:0]  psw_sav_ff;
    reg  [7:0]  pcl_ff;
    reg  [7:0]  pch_ff;
    reg         ram_we;
    reg  [7:0]  ram_waddr;
    reg  [7:0]  ram_wdata;
    reg  [7:0]  ram_raddr;
    wire [7:0]  ram_rdata;
    wire [15:0] req_vec;
    wire [3:0]  req_idx;
    wire        req_any;
    wire        idle;
    wire        start_trap;
    wire        start_irq;
    wire        apb_wr;
    wire        apb_setup;
    wire        mapped;
    reg  [31:0] rd_mux;

    // vector slot of a source index
    function [15:0] vec_of;
        input [3:0] idx;
        begin
            vec_of = `IER_VEC_TOP - {11'h000, idx, 1'b0};
        end
    endfunction

    // lowest index set wins, index zero means none
    function [3:0] prio_idx;
        input [15:0] req;
        integer i;
        begin
            prio_idx = 4'h0;
            for (i = `IER_SRC_HI; i >= `IER_NMI_LO; i = i - 1) begin
                if (req[i]) begin
                    prio_idx = i[3:0];
                end
            end
        end
    endfunction

    // ==========================================
    // acceptance qualification
    assign req_vec[`IER_SRC_HI:`IER_MASK_LO] =
        irq_pending_latch_ff[`IER_SRC_HI:`IER_MASK_LO]
        & source_irq_enable_ff[`IER_SRC_HI:`IER_MASK_LO]
        & {12{master_irq_enable_ff}};                          // RL20 RL6
    assign req_vec[`IER_NMI_HI:`IER_NMI_LO] =
        irq_pending_latch_ff[`IER_NMI_HI:`IER_NMI_LO];         // RL21
    assign req_vec[1:0]  = 2'b00;
    assign req_idx       = prio_idx(req_vec);                  // RL22
    assign req_any       = (req_idx != 4'h0);
    assign idle          = (state_ff == ST_IDLE);
    assign start_trap    = undef_exec | (swi_exec & idle);     // RL13 RL16 RL17
    assign start_irq     = idle & instr_last & req_any
                           & ~start_trap & ~ret_exec;          // RL12 RL5

    // ==========================================
    // apb decode
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pready_ff & pwrite;
    assign mapped    = (paddr == `IER_OFS_ENABLE) | (paddr == `IER_OFS_LATCH)
                       | (paddr == `IER_OFS_STATUS) | (paddr == `IER_OFS_SP);

    // read data select
    always @* begin
        if (paddr == `IER_OFS_ENABLE) begin
            rd_mux = {16'h0000, source_irq_enable_ff[15:1], master_irq_enable_ff};
        end else if (paddr == `IER_OFS_LATCH) begin
            rd_mux = {16'h0000, irq_pending_latch_ff};
        end else if (paddr == `IER_OFS_STATUS) begin
            rd_mux = {16'h0000, 4'h0, src_ff, 4'h0, state_ff};
        end else if (paddr == `IER_OFS_SP) begin
            rd_mux = {24'h000000, sp_ff};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    // one wait-free access phase, error on unmapped
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
        end else begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup & ~mapped;
            if (apb_setup) begin
                prdata_ff <= rd_mux;
            end
        end
    end

    // ==========================================
    // stack ram port selection per state
    always @* begin
        ram_we    = 1'b0;
        ram_waddr = sp_ff;
        ram_wdata = psw_sav_ff;
        ram_raddr = sp_ff + `IER_ONE;
        case (state_ff)
            ST_PSH0: begin
                ram_we = 1'b1;                                  // RL3
            end
            ST_PSH1: begin
                ram_we    = 1'b1;
                ram_wdata = pc_sav_ff[15:8];                    // RL3
            end
            ST_PSH2: begin
                ram_we    = 1'b1;
                ram_wdata = pc_sav_ff[7:0];                     // RL3 RL10
            end
            ST_POP1: begin
                ram_raddr = sp_ff + `IER_TWO;                   // RL10
            end
            ST_POP2: begin
                ram_raddr = sp_ff + `IER_STACK_BYTES;
            end
            default: begin
                ram_raddr = sp_ff + `IER_ONE;
            end
        endcase
    end

    ier_stack_ram #(
        .AW (8),
        .DW (8)
    ) u_stack (
        .clk      (pclk),
        .rst_n    (presetn),
        .we       (ram_we),
        .waddr    (ram_waddr),
        .wdata    (ram_wdata),
        .raddr    (ram_raddr),
        .rdata_ff (ram_rdata)
    );

    // ==========================================
    // sequencer, master enable, stack pointer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff             <= ST_IDLE;
            master_irq_enable_ff <= 1'b0;
            sp_ff                <= `IER_SP_RST;
            src_ff               <= 4'h0;
            pc_sav_ff            <= 16'h0000;
            psw_sav_ff           <= 8'h00;
            pcl_ff               <= 8'h00;
            pch_ff               <= 8'h00;
            core_hold_ff         <= 1'b0;
            pc_load_ff           <= 1'b0;
            pc_value_ff          <= 16'h0000;
            psw_load_ff          <= 1'b0;
            psw_value_ff         <= 8'h00;
            vec_addr_ff          <= 16'h0000;
            vec_rd_ff            <= 1'b0;
        end else begin
            pc_load_ff  <= 1'b0;
            psw_load_ff <= 1'b0;
            vec_rd_ff   <= 1'b0;
            if (apb_wr && (paddr == `IER_OFS_ENABLE)) begin
                master_irq_enable_ff <= pwdata[`IER_IMF_BIT];
            end
            if (apb_wr && (paddr == `IER_OFS_SP)) begin
                sp_ff <= pwdata[7:0];
            end
            // only pc and status are saved, never the general registers
            if (start_trap || start_irq) begin                  // RL8
                state_ff             <= ST_PSH0;
                src_ff               <= start_trap ? `IER_TRAP_IDX : req_idx;
                master_irq_enable_ff <= 1'b0;                   // RL1
                pc_sav_ff            <= core_pc;
                psw_sav_ff           <= {core_psw[7:1], master_irq_enable_ff};
                core_hold_ff         <= 1'b1;
            end else begin
                case (state_ff)
                    ST_IDLE: begin
                        if (ret_exec) begin
                            state_ff     <= ST_POP0;
                            core_hold_ff <= 1'b1;
                        end
                    end
                    ST_PSH0: begin
                        sp_ff    <= sp_ff - `IER_ONE;
                        state_ff <= ST_PSH1;
                    end
                    ST_PSH1: begin
                        sp_ff    <= sp_ff - `IER_ONE;
                        state_ff <= ST_PSH2;
                    end
                    ST_PSH2: begin
                        sp_ff    <= sp_ff - `IER_ONE;           // RL3
                        state_ff <= ST_VEC;
                    end
                    ST_VEC: begin
                        vec_addr_ff <= vec_of(src_ff);          // RL4 RL18 RL19
                        vec_rd_ff   <= 1'b1;
                        state_ff    <= ST_VECW;
                    end
                    ST_VECW: begin
                        if (!vec_rd_ff) begin
                            pc_value_ff  <= vec_data;           // RL4
                            pc_load_ff   <= 1'b1;
                            core_hold_ff <= 1'b0;
                            state_ff     <= ST_IDLE;
                        end
                    end
                    ST_POP0: begin
                        state_ff <= ST_POP1;
                    end
                    ST_POP1: begin
                        pcl_ff   <= ram_rdata;
                        state_ff <= ST_POP2;
                    end
                    ST_POP2: begin
                        pch_ff   <= ram_rdata;
                        state_ff <= ST_POP3;
                    end
                    ST_POP3: begin
                        pc_value_ff          <= {pch_ff, pcl_ff};       // RL9
                        psw_value_ff         <= ram_rdata;
                        master_irq_enable_ff <= ram_rdata[`IER_PSW_IMF_BIT];
                        pc_load_ff           <= 1'b1;
                        psw_load_ff          <= 1'b1;
                        sp_ff                <= sp_ff + `IER_STACK_BYTES;
                        core_hold_ff         <= 1'b0;
                        state_ff             <= ST_IDLE;
                    end
                    default: begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // source enables, written over apb only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            source_irq_enable_ff <= `IER_EN_RST;
        end else if (apb_wr && (paddr == `IER_OFS_ENABLE)) begin
            source_irq_enable_ff <= {pwdata[15:4], 4'h0};
        end
    end

    // ==========================================
    // pending latches: set beats any clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_pending_latch_ff <= `IER_LATCH_RST;
        end else begin
            irq_pending_latch_ff <=
                (irq_pending_latch_ff
                 & ~((apb_wr && (paddr == `IER_OFS_LATCH))
                     ? ~pwdata[15:0] : 16'h0000)
                 & ~((start_irq && !start_trap)
                     ? (16'h0001 << req_idx) : 16'h0000))  // RL2
                | {irq_src_req, 2'b00};
        end
    end

    // ==========================================
    // fetch monitor: missing memory and trap regions
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_opcode_ff  <= 8'h00;
            addr_trap_rst_ff <= 1'b0;
        end else begin
            if (single_chip && (fetch_addr > RAM_TOP) && (fetch_addr < ROM_BASE)) begin
                fetch_opcode_ff <= `IER_OPC_SWI;               // RL14
            end else begin
                fetch_opcode_ff <= fetch_rdata;
            end
            addr_trap_rst_ff <= fetch_valid && (fetch_addr <= RAM_TOP); // RL15
        end
    end
endmodule

// >>> tb/ier_core_irq_properties.sv
// concurrent checks on the interrupt sequencer ports
`timescale 1ns/10ps
module ier_core_irq_properties #(
    parameter RAM_TOP  = 16'h00ff,
    parameter ROM_BASE = 16'hf000
) (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pready_ff,
    input logic        swi_exec,
    input logic        undef_exec,
    input logic        ret_exec,
    input logic        single_chip,
    input logic        fetch_valid,
    input logic [15:0] fetch_addr,
    input logic        core_hold_ff,
    input logic        pc_load_ff,
    input logic        psw_load_ff,
    input logic [7:0]  psw_value_ff,
    input logic [15:0] vec_addr_ff,
    input logic        vec_rd_ff,
    input logic        master_irq_enable_ff,
    input logic [7:0]  fetch_opcode_ff,
    input logic        addr_trap_rst_ff,
    input logic [7:0]  sp_ff
);
// ====================
// bus and sequencer relations
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
chk_apb_ready: assert property (psel && !penable |=> pready_ff ##1 !pready_ff)
    else $error("ready is not one pulse per access");
chk_accept_mask: assert property ($rose(core_hold_ff) && !$past(ret_exec)
    |-> !master_irq_enable_ff) else $error("master enable kept on entry");
chk_push_sp: assert property (pc_load_ff && !psw_load_ff && !$past(core_hold_ff, 7)
    |-> sp_ff == $past(sp_ff, 7) - 8'h03) else $error("stack pointer not down by three");
chk_ret_restore: assert property (psw_load_ff |-> pc_load_ff
    && master_irq_enable_ff == psw_value_ff[0] && sp_ff == $past(sp_ff, 5) + 8'h03)
    else $error("return restore wrong");
chk_ret_time: assert property (ret_exec && !core_hold_ff && !undef_exec
    |-> ##5 psw_load_ff) else $error("return load late");
chk_load_hold: assert property (pc_load_ff |-> !core_hold_ff && $past(core_hold_ff))
    else $error("pc load outside sequence end");
chk_swi_vector: assert property (swi_exec && !core_hold_ff && !undef_exec && !ret_exec
    |-> ##5 (vec_rd_ff && vec_addr_ff == 16'hfffc) ##2 pc_load_ff)
    else $error("trap vector sequence wrong");
chk_undef_abort: assert property (undef_exec
    |-> ##5 (vec_rd_ff && vec_addr_ff == 16'hfffc) ##2 pc_load_ff)
    else $error("illegal opcode sequence wrong");
chk_fetch_missing: assert property (single_chip && fetch_valid && fetch_addr > RAM_TOP
    && fetch_addr < ROM_BASE |=> fetch_opcode_ff == 8'hff) else $error("no ff opcode");
chk_trap_reset: assert property (fetch_valid && fetch_addr <= RAM_TOP
    |=> addr_trap_rst_ff) else $error("no trap reset");
endmodule
bind ier_core_irq ier_core_irq_properties #(.RAM_TOP(RAM_TOP), .ROM_BASE(ROM_BASE))
    u_props (.*);

// >>> tb/ier_src_model.sv
// peripheral request sources and vector table model
`timescale 1ns/10ps
module ier_src_model (
    input  logic        pclk,
    input  logic        presetn,
    input  logic        raise_go,
    input  logic [15:2] raise_mask,
    input  logic        vec_rd_ff,
    input  logic [15:0] vec_addr_ff,
    output logic [15:2] irq_src_req,
    output logic [15:0] vec_data
);
// ====================
// one-cycle request pulses, vector word one cycle after the strobe
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_src_req <= 14'h0000;
        vec_data    <= 16'h0000;
    end else begin
        irq_src_req <= raise_go ? raise_mask : 14'h0000;
        vec_data    <= vec_rd_ff ? {vec_addr_ff[7:0], 8'h10} : ~vec_data; // never stale
    end
end
endmodule

// >>> tb/cpu_interrupt_entry_return_test.sv
// self-checking bench for the interrupt entry and return sequencer
`timescale 1ns/10ps
module cpu_interrupt_entry_return_test;
logic        pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, e;
logic [11:0] paddr;
logic [31:0] pwdata, prdata_ff, q;
logic [15:2] irq_src_req, raise_mask;
logic        instr_last, swi_exec, undef_exec, ret_exec, single_chip, fetch_valid;
logic [15:0] core_pc, vec_data, fetch_addr, pc_value_ff, vec_addr_ff;
logic [7:0]  core_psw, fetch_rdata, psw_value_ff, fetch_opcode_ff, sp_ff;
logic        core_hold_ff, pc_load_ff, psw_load_ff, vec_rd_ff, raise_go;
logic        master_irq_enable_ff, addr_trap_rst_ff;
int          n_errors = 0;
int          samples_checked = 0;
int          lat;
ier_core_irq i_dut (.*);
ier_src_model i_src (.*);
// ====================
// clock and watchdog
initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
end
initial begin
    repeat (3000) @(posedge pclk);
    n_errors = n_errors + 1;
    wrap_up;
end
// ====================
// tasks
task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // look mid-cycle so the sampled answer is the one standing at the next edge
    do begin
        @(negedge pclk);
        n++;
    end while (pready_ff !== 1'b1 && n < 50);
    if (n >= 50) begin
        n_errors = n_errors + 1;
    end
    q = prdata_ff;
    e = pslverr_ff;
    @(posedge pclk);
    {psel, penable} <= 2'b00;
endtask
task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
endtask
task raise(input logic [15:0] m);
    @(posedge pclk);
    {raise_go, raise_mask} <= {1'b1, m[15:2]};
    @(posedge pclk);
    raise_go <= 1'b0;
    repeat (2) @(posedge pclk);
endtask
// pulse of {instr_last, swi_exec, undef_exec, ret_exec}
task step(input logic [3:0] v);
    @(posedge pclk);
    {instr_last, swi_exec, undef_exec, ret_exec} <= v;
    @(posedge pclk);
    {instr_last, swi_exec, undef_exec, ret_exec} <= 4'h0;
endtask
task wait_load;
    lat = 0;
    do begin
        @(posedge pclk);
        lat++;
    end while (pc_load_ff !== 1'b1 && lat < 40);
endtask
task fe(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    {fetch_valid, fetch_addr, fetch_rdata} <= {1'b1, a, d};
    @(posedge pclk);
    fetch_valid <= 1'b0;
    @(negedge pclk);
endtask
function logic [15:0] ent(input logic [3:0] i);
    logic [15:0] v;
    v = 16'hfffe - {11'h000, i, 1'b0};
    ent = {v[7:0], 8'h10};
endfunction
task wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
// ====================
// main sequence
initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {instr_last, swi_exec, undef_exec, ret_exec, single_chip} = '0;
    {fetch_valid, fetch_addr, fetch_rdata, raise_go, raise_mask} = '0;
    core_pc = 16'h1234;
    core_psw = 8'ha6;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk(sp_ff, 8'hff);
    rd(12'h00c, 32'hff);
    rd(12'h000, 32'h0);
    rd(12'h010, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 12'h000, 32'h31);
    raise(16'h0070);
    step(4'h8);
    wait_load;
    chk(pc_value_ff, ent(4));
    chk(lat <= 38, 1'b1);
    chk(master_irq_enable_ff, 1'b0);
    chk(sp_ff, 8'hfc);
    rd(12'h004, 32'h60);
    step(4'h8);
    repeat (3) @(posedge pclk);
    chk(core_hold_ff, 1'b0);
    core_pc <= 16'h5555;
    core_psw <= 8'h00;
    step(4'h1);
    wait_load;
    chk(pc_value_ff, 16'h1234);
    chk(psw_value_ff, 8'ha7);
    chk(master_irq_enable_ff, 1'b1);
    chk(sp_ff, 8'hff);
    step(4'h8);
    wait_load;
    chk(pc_value_ff, ent(5));
    apb(1'b1, 12'h000, 32'h01);
    step(4'h8);
    repeat (3) @(posedge pclk);
    chk(core_hold_ff, 1'b0);
    step(4'h1);
    wait_load;
    chk(sp_ff, 8'hff);
    apb(1'b1, 12'h000, 32'h0);
    raise(16'h0008);
    step(4'h8);
    wait_load;
    chk(pc_value_ff, ent(3));
    raise(16'h0004);
    step(4'h8);
    step(4'h2);
    wait_load;
    chk(pc_value_ff, ent(1));
    step(4'h4);
    wait_load;
    chk(pc_value_ff, ent(1));
    apb(1'b1, 12'h00c, 32'hff);
    rd(12'h00c, 32'hff);
    single_chip <= 1'b1;
    fe(16'h8000, 8'h3c);
    chk(fetch_opcode_ff, 8'hff);
    fe(16'hf100, 8'h3c);
    chk(fetch_opcode_ff, 8'h3c);
    fe(16'h0050, 8'h3c);
    chk(addr_trap_rst_ff, 1'b1);
    fe(16'h0020, 8'h3c);
    chk(addr_trap_rst_ff, 1'b1);
    single_chip <= 1'b0;
    fe(16'h8000, 8'h3c);
    chk(fetch_opcode_ff, 8'h3c);
    wrap_up;
end
endmodule
